// ### cgsb_pkg.sv
/*
  constants for the clock generator stop and break control block:
  register offsets, field positions, reset values, state codes.
  assumes a 32-bit axi4-lite register bus, byte addressed.
*/
package cgsb_pkg;
  // register byte offsets
  localparam logic [7:0] CGSB_PLL_CTRL_OFS = 8'h00;
  localparam logic [7:0] CGSB_RANGE_OFS = 8'h04;
  localparam logic [7:0] CGSB_CONFIG_OFS = 8'h08;
  localparam logic [7:0] CGSB_IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] CGSB_IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] CGSB_STATE_OFS = 8'h14;
  // pll control register fields
  localparam int CGSB_PON_BIT = 0;
  localparam int CGSB_BCS_BIT = 1;
  localparam int CGSB_AUTO_BIT = 2;
  localparam int CGSB_FLAG_BIT = 3;
  localparam int CGSB_LOCK_BIT = 4;
  // irq status / mask fields
  localparam int CGSB_EV_LOCK = 0;
  localparam int CGSB_EV_STOP = 1;
  localparam int CGSB_EV_WAKE = 2;
  localparam int CGSB_EV_N = 3;
  // reset values
  localparam logic CGSB_PON_RST = 1'b1;
  localparam logic [7:0] CGSB_RANGE_RST = 8'h40;
  localparam logic CGSB_OSCRUN_RST = 1'b0;
  // cycles the bus clock mux gets to settle before gating
  localparam int CGSB_SWITCH_CYCLES = 2;
  // axi responses
  localparam logic [1:0] CGSB_RESP_OKAY = 2'b00;
  localparam logic [1:0] CGSB_RESP_SLVERR = 2'b10;
  // stop sequencer states
  typedef enum logic [1:0] {
    CGSB_RUN = 2'b00,
    CGSB_SWITCH = 2'b01,
    CGSB_STOPPED = 2'b10,
    CGSB_RESUME = 2'b11
  } cgsb_state_t;
endpackage

// ### cgsb_stop_break_ctrl.sv
/*
  clock generator stop and break control: decides what the oscillator,
  pll and clock gates do on stop, moves the bus clock back to the
  crystal, guards the pll lock-change flag during break.
  assumes stop, wake and break inputs come from logic on this clock;
  the pll lock level comes from the analog pll and is synchronised.
*/
// Functional notes
// R1: config clear: stop kills oscillator, pll, outputs low
// R2: stop on vco clock clears base select
// R3: after stop bus clock is crystal, select clear
// R4: config set: stop powers down only pll
// R5: break clears allowed only when enable bit set
// R6: flag cleared in break stays cleared afterwards
// R7: enable clear: break accesses leave flag alone
// R8: base select set forces pll power on
// R9: pll off or range zero clears base select
// R10: auto bandwidth off: flag, lock read zero
// R11: source switch settles before outputs forced low
`timescale 1ns/1ps
module cgsb_stop_break_ctrl import cgsb_pkg::*; #(
  parameter int SWITCH_CYCLES = CGSB_SWITCH_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // system integration unit and core
  input wire logic stopRequest,
  input wire logic wakeRequest,
  input wire logic breakState,
  input wire logic breakFlagClearEnable,
  // analog pll lock level
  input wire logic pllLockPin,
  // clock generator controls
  output logic oscEnable,
  output logic pllEnable,
  output logic crystalClockOut,
  output logic busClockOut,
  output logic busClkSelVco,
  output logic clockGenIrq,
  output logic stopActive
);
  // crystalClockOut / busClockOut are gate enables of those clocks
  // settle counter is 8 bits wide, so the count must fit in it
  if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 255) begin : g_bad_cycles
    $error("SWITCH_CYCLES out of range");
  end
  cgsb_state_t stState, next_stState; // stop sequencer
  logic [7:0] swCnt, vcoRangeSelect; // settle counter, vco range
  logic pllPowerOn, baseClockSelect, autoBw, oscRunInStopCfg; // control bits
  logic pllLockChangeFlag; // sticky, hidden while auto bandwidth is off
  logic [CGSB_EV_N-1:0] irqStat, irqMask; // sticky events and their mask
  logic lockMeta; // first sync stage, read only by lockSync
  logic lockSync, lockPrev, lockChange; // synced level, last level, edge
  logic awHave, wHave; // write halves held
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ, next_rdata;
  logic [3:0] wStrbQ;
  logic doWrite, wrCtrl, clrAllowed, next_rerr;

  // write fires once both halves are held and no response pends
  assign doWrite = awHave && wHave && !bvalid;
  assign wrCtrl = doWrite && awAddrQ == CGSB_PLL_CTRL_OFS && wStrbQ[0];
  // in break, clears pass only with the enable bit high
  assign clrAllowed = !breakState || breakFlagClearEnable; // R5
  assign lockChange = autoBw && lockSync != lockPrev;

  // lock level synchroniser, two stages before any logic
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lockMeta <= 1'b0;
      lockSync <= 1'b0;
      lockPrev <= 1'b0;
    end else begin
      lockMeta <= pllLockPin;
      lockSync <= lockMeta;
      lockPrev <= lockSync;
    end
  end

  // write address / data capture, either order
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHave <= 1'b1;
        awready <= 1'b0;
        awAddrQ <= awaddr;
      end else if (doWrite) begin
        awHave <= 1'b0;
      end
      if (wvalid && wready) begin
        wHave <= 1'b1;
        wready <= 1'b0;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end else if (doWrite) begin
        wHave <= 1'b0;
      end
      // reopen both channels once the response is taken
      if (bvalid && bready) begin
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp <= CGSB_RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= (awAddrQ > CGSB_STATE_OFS || awAddrQ[1:0] != 2'b00) ?
        CGSB_RESP_SLVERR : CGSB_RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data mux; flag and lock hidden while auto bandwidth is off
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    case (araddr)
      CGSB_PLL_CTRL_OFS: begin
        next_rdata[CGSB_PON_BIT] = pllPowerOn;
        next_rdata[CGSB_BCS_BIT] = baseClockSelect;
        next_rdata[CGSB_AUTO_BIT] = autoBw;
        next_rdata[CGSB_FLAG_BIT] = pllLockChangeFlag && autoBw; // R10
        next_rdata[CGSB_LOCK_BIT] = lockSync && autoBw; // R10
      end
      CGSB_RANGE_OFS: next_rdata[7:0] = vcoRangeSelect;
      CGSB_CONFIG_OFS: next_rdata[0] = oscRunInStopCfg;
      CGSB_IRQ_STAT_OFS: next_rdata[CGSB_EV_N-1:0] = irqStat;
      CGSB_IRQ_MASK_OFS: next_rdata[CGSB_EV_N-1:0] = irqMask;
      CGSB_STATE_OFS: next_rdata[1:0] = stState;
      default: next_rerr = 1'b1;
    endcase
  end

  // read channel; a read never disturbs any flag
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= CGSB_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rerr ? CGSB_RESP_SLVERR : CGSB_RESP_OKAY;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      autoBw <= 1'b0;
      vcoRangeSelect <= CGSB_RANGE_RST;
      oscRunInStopCfg <= CGSB_OSCRUN_RST;
      irqMask <= '0;
    end else if (doWrite && wStrbQ[0]) begin
      case (awAddrQ)
        CGSB_PLL_CTRL_OFS: autoBw <= wDataQ[CGSB_AUTO_BIT];
        CGSB_RANGE_OFS: vcoRangeSelect <= wDataQ[7:0];
        CGSB_CONFIG_OFS: oscRunInStopCfg <= wDataQ[0];
        CGSB_IRQ_MASK_OFS: irqMask <= wDataQ[CGSB_EV_N-1:0];
        default: ;
      endcase
    end
  end

  // pll power: locked on while base select is set
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pllPowerOn <= CGSB_PON_RST;
    end else if (wrCtrl && !baseClockSelect) begin
      pllPowerOn <= wDataQ[CGSB_PON_BIT]; // R8
    end
  end
  // base clock select; hardware clears beat software writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      baseClockSelect <= 1'b0;
    end else if (!pllPowerOn || vcoRangeSelect == 8'h00) begin
      baseClockSelect <= 1'b0; // R9
    end else if (stState == CGSB_RUN && stopRequest) begin
      baseClockSelect <= 1'b0; // R2
    end else if (stState != CGSB_RUN) begin
      baseClockSelect <= 1'b0; // R3
    end else if (wrCtrl) begin
      // power data only counts while select is clear: it is locked on after
      baseClockSelect <= wDataQ[CGSB_BCS_BIT] && (wDataQ[CGSB_PON_BIT] || baseClockSelect); // R8
    end
  end

  // lock-change flag: set wins, write clear only when clears are allowed, auto bandwidth off clears it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pllLockChangeFlag <= 1'b0;
    end else if (!autoBw) begin
      pllLockChangeFlag <= 1'b0; // R10
    end else if (lockChange) begin
      pllLockChangeFlag <= 1'b1;
    end else if (wrCtrl && wDataQ[CGSB_FLAG_BIT] && clrAllowed) begin
      // a clear made in break is plain state: it simply stays
      pllLockChangeFlag <= 1'b0; // R6 R7
    end
  end

  // sticky interrupt events, write one to clear
  for (genvar i = 0; i < CGSB_EV_N; i++) begin : g_ev
    logic evHit;
    always_comb begin
      case (i)
        CGSB_EV_LOCK: evHit = lockChange;
        CGSB_EV_STOP: evHit = stState == CGSB_RUN && stopRequest;
        default: evHit = stState == CGSB_RESUME;
      endcase
    end
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        irqStat[i] <= 1'b0;
      end else if (evHit) begin
        irqStat[i] <= 1'b1;
      end else if (doWrite && wStrbQ[0] && awAddrQ == CGSB_IRQ_STAT_OFS &&
                   wDataQ[i] && clrAllowed) begin
        irqStat[i] <= 1'b0; // R5
      end
    end
  end

  // stop sequencer next state
  always_comb begin
    next_stState = stState;
    case (stState)
      CGSB_RUN: if (stopRequest) next_stState = CGSB_SWITCH;
      // give the bus clock mux time to hop cleanly
      CGSB_SWITCH: if (swCnt == 8'(SWITCH_CYCLES - 1)) next_stState = CGSB_STOPPED; // R11
      CGSB_STOPPED: if (wakeRequest) next_stState = CGSB_RESUME;
      CGSB_RESUME: next_stState = CGSB_RUN;
      default: next_stState = CGSB_RUN;
    endcase
  end
  // state and settle counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stState <= CGSB_RUN;
      swCnt <= 8'h00;
    end else begin
      stState <= next_stState;
      swCnt <= (stState == CGSB_SWITCH) ? swCnt + 8'h01 : 8'h00;
    end
  end

  // clock controls, registered off the next state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oscEnable <= 1'b1;
      pllEnable <= CGSB_PON_RST;
      crystalClockOut <= 1'b1;
      busClockOut <= 1'b1;
      busClkSelVco <= 1'b0;
      stopActive <= 1'b0;
    end else begin
      // oscillator survives stop only with the run-in-stop bit
      oscEnable <= next_stState != CGSB_STOPPED || oscRunInStopCfg; // R1 R4
      crystalClockOut <= next_stState != CGSB_STOPPED || oscRunInStopCfg; // R1
      pllEnable <= pllPowerOn && next_stState != CGSB_STOPPED; // R1 R4
      busClockOut <= next_stState != CGSB_STOPPED; // R1
      busClkSelVco <= baseClockSelect && next_stState == CGSB_RUN &&
                      !(stState == CGSB_RUN && stopRequest); // R2 R3
      stopActive <= next_stState == CGSB_STOPPED;
    end
  end

  // interrupt line, forced low while stopped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clockGenIrq <= 1'b0;
    end else begin
      clockGenIrq <= |(irqStat & irqMask) && next_stState != CGSB_STOPPED; // R1
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_bcs_pon;
    baseClockSelect |-> pllPowerOn;
  endproperty
  a_bcs_pon: assert property (p_bcs_pon) else $error("base select without power"); // R8
  property p_pon_held;
    baseClockSelect && wrCtrl && !wDataQ[CGSB_PON_BIT] |=> pllPowerOn;
  endproperty
  a_pon_held: assert property (p_pon_held) else $error("power cleared under select"); // R8
  property p_range_zero;
    (vcoRangeSelect == 8'h00 || !pllPowerOn) |=> !baseClockSelect;
  endproperty
  a_range_zero: assert property (p_range_zero) else $error("select survived range zero"); // R9
  property p_stop_clear;
    stState == CGSB_RUN && stopRequest |=> !baseClockSelect && !busClkSelVco;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("select not cleared on stop"); // R2
  property p_settle;
    stState == CGSB_RUN && stopRequest |=> busClockOut [*2] ##1 !busClockOut;
  endproperty
  a_settle: assert property (p_settle) else $error("bus clock gated too soon"); // R11
  property p_stopped_low;
    stState == CGSB_STOPPED |-> !busClockOut && !clockGenIrq && !pllEnable;
  endproperty
  a_stopped_low: assert property (p_stopped_low) else $error("outputs alive in stop"); // R1
  property p_osc_cfg;
    stState == CGSB_STOPPED |-> oscEnable == oscRunInStopCfg &&
      crystalClockOut == oscRunInStopCfg;
  endproperty
  a_osc_cfg: assert property (p_osc_cfg) else $error("oscillator wrong in stop"); // R1 R4
  property p_resume;
    stState == CGSB_RESUME |=> !baseClockSelect && !busClkSelVco && busClockOut;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not on crystal"); // R3
  property p_break_flag;
    breakState && !breakFlagClearEnable && pllLockChangeFlag && autoBw
      |=> pllLockChangeFlag || !autoBw;
  endproperty
  a_break_flag: assert property (p_break_flag) else $error("flag lost in break"); // R7
  property p_auto_off;
    !autoBw |=> !pllLockChangeFlag;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("flag set with auto off"); // R10

  c_stop_wake: cover property (stState == CGSB_STOPPED ##1 stState == CGSB_RESUME);
  c_stop_vco: cover property (busClkSelVco && stopRequest);
  c_break_clr: cover property (breakState && breakFlagClearEnable && wrCtrl);
  c_osc_run: cover property (stState == CGSB_STOPPED && oscEnable);
endmodule

// ### cgsb_core_model.sv
/*
  partner model: core and system integration unit seen from the
  stop and break control block (stop pulse, wake, break, clear enable).
  assumes one clock and the same active-low asynchronous reset.
*/
`timescale 1ns/1ps
module cgsb_core_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cmdStop, // level from bench, one pulse made of it
  input wire logic cmdWake,
  input wire logic cmdBreak,
  input wire logic cmdClrEn,
  output logic stopRequest,
  output logic wakeRequest,
  output logic breakState,
  output logic breakFlagClearEnable
);
  logic stopSeen; // last command level, for edge detect

  // one pulse per command: a stop instruction executes once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stopRequest <= 1'b0;
      stopSeen <= 1'b0;
    end else begin
      stopRequest <= cmdStop & ~stopSeen;
      stopSeen <= cmdStop;
    end
  end

  // levels follow commands one cycle late, like a registered unit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wakeRequest <= 1'b0;
      breakState <= 1'b0;
      breakFlagClearEnable <= 1'b0;
    end else begin
      wakeRequest <= cmdWake;
      breakState <= cmdBreak;
      breakFlagClearEnable <= cmdClrEn;
    end
  end
endmodule

// ### cgsb_stop_break_ctrl_tb.sv
/*
  self-checking bench for the stop and break control block.
  assumes the register map and timing of the package and hand-over.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cgsb_stop_break_ctrl_tb import cgsb_pkg::*;;
  logic clock = 1'b0;
  logic nrst;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic stopRequest, wakeRequest, breakState, breakFlagClearEnable;
  logic cmdStop, cmdWake, cmdBreak, cmdClrEn, pllLockPin;
  logic oscEnable, pllEnable, crystalClockOut, busClockOut;
  logic busClkSelVco, clockGenIrq, stopActive;
  logic [1:0] resp; // last bus response
  logic [31:0] data; // last read data
  logic irqA; // interrupt level under the first mask
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  always #20 clock = ~clock;

  cgsb_stop_break_ctrl u_cgsb_stop_break_ctrl (
    .clock, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .stopRequest, .wakeRequest,
    .breakState, .breakFlagClearEnable, .pllLockPin, .oscEnable,
    .pllEnable, .crystalClockOut, .busClockOut, .busClkSelVco,
    .clockGenIrq, .stopActive);

  cgsb_core_model u_cgsb_core_model (
    .clock, .nrst, .cmdStop, .cmdWake, .cmdBreak, .cmdClrEn,
    .stopRequest, .wakeRequest, .breakState, .breakFlagClearEnable);

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // axi write: both channels offered at once, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  // axi read: waits only for the slave's answer
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // reset levels, reset register values, unmapped place
  task automatic t_reset;
    `CHK({oscEnable, crystalClockOut, busClockOut, busClkSelVco}, 4'hE)
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_0001)
    rd(CGSB_RANGE_OFS);
    `CHK(data, 32'h0000_0040)
    rd(8'h18);
    `CHK({resp, data}, {CGSB_RESP_SLVERR, 32'h0000_0000})
    wr(8'h18, 32'h0000_00FF);
    `CHK(resp, CGSB_RESP_SLVERR)
  endtask

  // base select refused with range zero or pll off
  task automatic t_range;
    wr(CGSB_RANGE_OFS, 32'h0000_0000);
    wr(CGSB_PLL_CTRL_OFS, 32'h0000_0003);
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_0001)
    wr(CGSB_RANGE_OFS, 32'h0000_0040);
    wr(CGSB_PLL_CTRL_OFS, 32'h0000_0002);
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_0000)
    wr(CGSB_PLL_CTRL_OFS, 32'h0000_0001);
  endtask

  // stop from the vco clock, then wake; cfg picks oscillator fate
  task automatic t_stop(input logic cfg);
    wr(CGSB_CONFIG_OFS, {31'h0000_0000, cfg});
    wr(CGSB_PLL_CTRL_OFS, 32'h0000_0003);
    wr(CGSB_PLL_CTRL_OFS, 32'h0000_0002);
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_0003)
    cmdStop <= 1'b1;
    do @(posedge clock); while (stopRequest !== 1'b1);
    cmdStop <= 1'b0;
    @(posedge clock);
    `CHK({busClkSelVco, busClockOut}, 2'b01)
    @(posedge clock);
    `CHK(busClockOut, 1'b1)
    @(posedge clock);
    `CHK({busClockOut, pllEnable, oscEnable, crystalClockOut}, {2'b00, cfg, cfg})
    `CHK({clockGenIrq, stopActive}, 2'b01)
    cmdWake <= 1'b1;
    do @(posedge clock); while (stopActive !== 1'b0);
    cmdWake <= 1'b0;
    `CHK({oscEnable, crystalClockOut, busClockOut, busClkSelVco}, 4'hE)
    cyc(2);
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_0001)
  endtask

  // lock-change flag against break and its clear enable
  task automatic t_break;
    pllLockPin <= 1'b1;
    cyc(6);
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_0001)
    wr(CGSB_PLL_CTRL_OFS, 32'h0000_0005);
    pllLockPin <= 1'b0;
    cyc(6);
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_000D)
    cmdBreak <= 1'b1;
    cyc(2);
    wr(CGSB_PLL_CTRL_OFS, 32'h0000_000D);
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_000D)
    cmdClrEn <= 1'b1;
    cyc(2);
    wr(CGSB_PLL_CTRL_OFS, 32'h0000_000D);
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_0005)
    cmdBreak <= 1'b0;
    cmdClrEn <= 1'b0;
    cyc(2);
    rd(CGSB_PLL_CTRL_OFS);
    `CHK(data, 32'h0000_0005)
  endtask

  // sticky status, mask, level output, break-gated clear
  task automatic t_irq;
    rd(CGSB_IRQ_STAT_OFS);
    `CHK(data, 32'h0000_0007)
    wr(CGSB_IRQ_MASK_OFS, 32'h0000_0000);
    cyc(2);
    irqA = clockGenIrq;
    wr(CGSB_IRQ_MASK_OFS, 32'h0000_0007);
    cyc(2);
    `CHK({irqA, clockGenIrq}, 2'b01)
    cmdBreak <= 1'b1;
    cyc(2);
    wr(CGSB_IRQ_STAT_OFS, 32'h0000_0007);
    rd(CGSB_IRQ_STAT_OFS);
    `CHK(data, 32'h0000_0007)
    cmdBreak <= 1'b0;
    cyc(2);
    wr(CGSB_IRQ_STAT_OFS, 32'h0000_0007);
    cyc(2);
    rd(CGSB_IRQ_STAT_OFS);
    `CHK({clockGenIrq, data}, 33'h0_0000_0000)
  endtask

  task automatic finish_test;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      finish_test;
    end
  end

  initial begin
    nrst = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    {cmdStop, cmdWake, cmdBreak, cmdClrEn, pllLockPin} = '0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset;
    t_range;
    t_stop(1'b0);
    t_stop(1'b1);
    t_break;
    t_irq;
    finish_test;
  end
endmodule
